// File: design/ldp_regs.svh
// constants for the load-pair execution block
`ifndef LDP_REGS_SVH
`define LDP_REGS_SVH
`define LDP_ASI_PRIMARY 8'h80
`define LDP_ASI_QUAD_A 8'h24
`define LDP_ASI_QUAD_B 8'h2C
`define LDP_ASI_PRIV_BIT 7
`define LDP_WORD_OFS 64'h0000000000000004
`define LDP_IMM_W 13
`endif

// File: design/ldp_pkg.sv
// types for the load-pair execution block
package ldp_pkg;
    typedef enum logic [2:0] {
        LDP_IDLE,
        LDP_REQ0,
        LDP_REQ1,
        LDP_DONE
    } ldp_state_t;

    typedef struct packed {
        logic alt;
        logic operand_sel;
        logic [4:0] dest_reg;
        logic [63:0] source_reg_a;
        logic [63:0] source_reg_b;
        logic [12:0] signed_offset_imm;
        logic [7:0] inline_space_id;
    } ldp_issue_t;

    typedef struct packed {
        logic bad_opcode;
        logic misalign;
        logic priv_action;
        logic access_fault;
        logic access_error;
        logic translation_miss;
        logic protection;
        logic phys_watch;
        logic virt_watch;
    } ldp_traps_t;

    typedef struct packed {
        ldp_state_t st;
        logic alt;
        logic [4:0] rd;
        logic [63:0] ea;
        logic [7:0] asi;
        logic [31:0] word0;
        logic mem_req;
        logic [63:0] mem_addr;
        logic [7:0] mem_asi;
        logic mem_lock;
        logic busy;
        logic wr_en;
        logic [4:0] wr_idx_even;
        logic wr_even_en;
        logic [63:0] wr_even;
        logic [63:0] wr_odd;
        logic quad_req;
        logic trap_valid;
        ldp_traps_t traps;
    } ldp_state_reg_t;
endpackage : ldp_pkg

// File: design/ldp_exec.sv
// load-pair execution: address, checks, two word reads, pair commit
`timescale 1ns/10ps
`include "ldp_regs.svh"
// Function
// - word at address goes to even register, address plus 4 to odd
// - upper 32 bits of both destination registers are zero
// - destination zero writes only register 1
// - odd destination raises bad opcode trap, no load
// - little-endian: byte-swap each 32-bit word on its own
// - primary form always uses space identifier 80 hex
// - address is a plus b, or a plus sign-extended 13-bit immediate
// - successful load pair is atomic between its two reads
// - alternate space id from instruction or space register by select
// - space id bit 7 zero marks a privileged access
// - privileged space id in user mode raises privileged action trap
// - address not 8-byte aligned raises misalign trap
// - alternate ids 24 and 2C run as atomic quadword load
// - trap set per form; alternate adds privilege, drops access error
module ldp_exec (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic issue_valid_i,
    input wire ldp_pkg::ldp_issue_t issue_i,
    input wire logic privilege_state_bit_i,
    input wire logic [7:0] space_id_reg_i,
    input wire logic little_endian_i,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_rdata_i,
    input wire logic mem_access_fault_i,
    input wire logic mem_access_error_i,
    input wire logic mem_translation_miss_i,
    input wire logic mem_protection_i,
    input wire logic mem_phys_watch_i,
    input wire logic mem_virt_watch_i,
    output logic busy_o,
    output logic mem_req_o,
    output logic [63:0] mem_addr_o,
    output logic [7:0] mem_asi_o,
    output logic mem_lock_o,
    output logic quad_req_o,
    output logic wr_en_o,
    output logic wr_even_en_o,
    output logic [4:0] wr_idx_even_o,
    output logic [63:0] wr_even_data_o,
    output logic [63:0] wr_odd_data_o,
    output logic trap_valid_o,
    output ldp_pkg::ldp_traps_t traps_o
);
    logic nrst_meta_r;
    logic nrst_sync_r;
    ldp_pkg::ldp_state_reg_t s_r;
    ldp_pkg::ldp_state_reg_t s_nxt;

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        // release waits two edges so no flop leaves reset on a metastable level
        if (!nrst_i)
        begin
            nrst_meta_r <= 1'b0;
            nrst_sync_r <= 1'b0;
        end
        else
        begin
            nrst_meta_r <= 1'b1;
            nrst_sync_r <= nrst_meta_r;
        end
    end

    function automatic logic [31:0] ldp_swap(input logic [31:0] w,
                                             input logic le);
        ldp_swap = le ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
    endfunction : ldp_swap

    logic [63:0] ea_calc;
    logic [7:0] asi_calc;
    logic [31:0] word_in;
    ldp_pkg::ldp_traps_t mem_traps;

    always_comb
    begin
        ea_calc = issue_i.source_reg_a + (issue_i.operand_sel ?
            {{(64-`LDP_IMM_W){issue_i.signed_offset_imm[`LDP_IMM_W-1]}},
             issue_i.signed_offset_imm}
            : issue_i.source_reg_b);
        if (!issue_i.alt)
            asi_calc = `LDP_ASI_PRIMARY;
        else
            asi_calc = issue_i.operand_sel ? space_id_reg_i
                                           : issue_i.inline_space_id;
        word_in = ldp_swap(mem_rdata_i, little_endian_i);
        mem_traps = '0;
        mem_traps.access_fault = mem_access_fault_i;
        mem_traps.access_error = mem_access_error_i & ~s_r.alt;
        mem_traps.translation_miss = mem_translation_miss_i;
        mem_traps.protection = mem_protection_i;
        mem_traps.phys_watch = mem_phys_watch_i;
        mem_traps.virt_watch = mem_virt_watch_i;
    end

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.wr_en = 1'b0;
        s_nxt.trap_valid = 1'b0;
        s_nxt.quad_req = 1'b0;
        unique case (s_r.st)
            ldp_pkg::LDP_IDLE:
            begin
                // old traps show through the pulse cycle (memory traps from the DONE cycle on), then drop
                s_nxt.traps = '0;
                if (issue_valid_i)
                begin
                    s_nxt.alt = issue_i.alt;
                    s_nxt.rd = {issue_i.dest_reg[4:1], 1'b0};
                    s_nxt.ea = ea_calc;
                    s_nxt.asi = asi_calc;
                    s_nxt.traps.bad_opcode = issue_i.dest_reg[0];
                    s_nxt.traps.misalign = |ea_calc[2:0];
                    s_nxt.traps.priv_action = issue_i.alt
                        & ~privilege_state_bit_i
                        & ~asi_calc[`LDP_ASI_PRIV_BIT];
                    if (issue_i.dest_reg[0] || (|ea_calc[2:0])
                        || (issue_i.alt && !privilege_state_bit_i
                            && !asi_calc[`LDP_ASI_PRIV_BIT]))
                    begin
                        s_nxt.trap_valid = 1'b1;
                    end
                    else if (issue_i.alt && (asi_calc == `LDP_ASI_QUAD_A
                             || asi_calc == `LDP_ASI_QUAD_B))
                    begin
                        s_nxt.quad_req = 1'b1;
                    end
                    else
                    begin
                        s_nxt.busy = 1'b1;
                        s_nxt.mem_req = 1'b1;
                        s_nxt.mem_lock = 1'b1;
                        s_nxt.mem_addr = ea_calc;
                        s_nxt.mem_asi = asi_calc;
                        s_nxt.st = ldp_pkg::LDP_REQ0;
                    end
                end
            end
            ldp_pkg::LDP_REQ0:
            begin
                if (mem_ack_i)
                begin
                    if (|mem_traps)
                    begin
                        s_nxt.traps = mem_traps;
                        s_nxt.st = ldp_pkg::LDP_DONE;
                        s_nxt.mem_req = 1'b0;
                    end
                    else
                    begin
                        s_nxt.word0 = word_in;
                        s_nxt.mem_addr = s_r.ea + `LDP_WORD_OFS;
                        s_nxt.st = ldp_pkg::LDP_REQ1;
                    end
                end
            end
            ldp_pkg::LDP_REQ1:
            begin
                if (mem_ack_i)
                begin
                    s_nxt.mem_req = 1'b0;
                    s_nxt.st = ldp_pkg::LDP_DONE;
                    if (|mem_traps)
                        s_nxt.traps = mem_traps;
                    else
                    begin
                        s_nxt.wr_even = {32'h0, s_r.word0};
                        s_nxt.wr_odd = {32'h0, word_in};
                        s_nxt.wr_idx_even = s_r.rd;
                        s_nxt.wr_even_en = (s_r.rd != 5'h0);
                    end
                end
            end
            ldp_pkg::LDP_DONE:
            begin
                s_nxt.mem_lock = 1'b0;
                s_nxt.busy = 1'b0;
                s_nxt.trap_valid = |s_r.traps;
                s_nxt.wr_en = ~(|s_r.traps);
                s_nxt.st = ldp_pkg::LDP_IDLE;
            end
            default:
                s_nxt.st = ldp_pkg::LDP_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge nrst_sync_r)
    begin
        if (!nrst_sync_r)
        begin
            s_r <= '0;
            s_r.st <= ldp_pkg::LDP_IDLE;
        end
        else
            s_r <= s_nxt;
    end

    assign busy_o = s_r.busy;
    assign mem_req_o = s_r.mem_req;
    assign mem_addr_o = s_r.mem_addr;
    assign mem_asi_o = s_r.mem_asi;
    assign mem_lock_o = s_r.mem_lock;
    assign quad_req_o = s_r.quad_req;
    assign wr_en_o = s_r.wr_en;
    assign wr_even_en_o = s_r.wr_even_en;
    assign wr_idx_even_o = s_r.wr_idx_even;
    assign wr_even_data_o = s_r.wr_even;
    assign wr_odd_data_o = s_r.wr_odd;
    assign trap_valid_o = s_r.trap_valid;
    assign traps_o = s_r.traps;

    // trap checks resolve at issue, so no trapped pair reaches memory
    odd_dest_a: assert property (@(posedge core_clk_i)
        disable iff (!nrst_sync_r)
        issue_valid_i && !busy_o && issue_i.dest_reg[0]
        |=> trap_valid_o && traps_o.bad_opcode && !mem_req_o)
        else $error("odd destination not trapped");
    misalign_trap_a: assert property (@(posedge core_clk_i)
        disable iff (!nrst_sync_r)
        issue_valid_i && !busy_o && (|ea_calc[2:0])
        |=> trap_valid_o && traps_o.misalign && !mem_req_o)
        else $error("misaligned address not trapped");
    priv_trap_a: assert property (@(posedge core_clk_i)
        disable iff (!nrst_sync_r)
        issue_valid_i && !busy_o && issue_i.alt && !privilege_state_bit_i
        && !asi_calc[`LDP_ASI_PRIV_BIT]
        |=> trap_valid_o && traps_o.priv_action)
        else $error("privileged space not trapped");

    // address and space of the first word
    primary_asi_a: assert property (@(posedge core_clk_i)
        disable iff (!nrst_sync_r)
        $rose(mem_req_o) && !s_r.alt |-> mem_asi_o == `LDP_ASI_PRIMARY)
        else $error("primary form used wrong space");
    ea_form_a: assert property (@(posedge core_clk_i)
        disable iff (!nrst_sync_r)
        issue_valid_i && !busy_o && !issue_i.operand_sel ##1 mem_req_o
        |-> mem_addr_o == $past(issue_i.source_reg_a)
            + $past(issue_i.source_reg_b))
        else $error("register sum address wrong");
    space_inline_a: assert property (@(posedge core_clk_i)
        disable iff (!nrst_sync_r)
        issue_valid_i && !busy_o && issue_i.alt && !issue_i.operand_sel
        ##1 mem_req_o |-> mem_asi_o == $past(issue_i.inline_space_id))
        else $error("inline space id not used");
    space_reg_a: assert property (@(posedge core_clk_i)
        disable iff (!nrst_sync_r)
        issue_valid_i && !busy_o && issue_i.alt && issue_i.operand_sel
        ##1 mem_req_o |-> mem_asi_o == $past(space_id_reg_i))
        else $error("space register not used");

    // lock spans both reads so no other agent can split the pair
    lock_held_a: assert property (@(posedge core_clk_i)
        disable iff (!nrst_sync_r)
        mem_req_o |-> mem_lock_o)
        else $error("lock dropped during pair");
    pair_stable_a: assert property (@(posedge core_clk_i)
        disable iff (!nrst_sync_r)
        busy_o |=> $stable(s_r.ea) && $stable(s_r.rd))
        else $error("pair state changed while busy");
    second_addr_a: assert property (@(posedge core_clk_i)
        disable iff (!nrst_sync_r)
        s_r.st == ldp_pkg::LDP_REQ1
        |-> mem_addr_o == s_r.ea + `LDP_WORD_OFS)
        else $error("second word address wrong");

    // commit side: one pulse, both halves, only after every check
    upper_zero_a: assert property (@(posedge core_clk_i)
        disable iff (!nrst_sync_r)
        wr_en_o |-> wr_even_data_o[63:32] == 32'h0
        && wr_odd_data_o[63:32] == 32'h0)
        else $error("upper half not zero");
    no_partial_a: assert property (@(posedge core_clk_i)
        disable iff (!nrst_sync_r)
        trap_valid_o |-> !wr_en_o)
        else $error("write on trapped pair");
    commit_late_a: assert property (@(posedge core_clk_i)
        disable iff (!nrst_sync_r)
        wr_en_o |-> $past(s_r.st) == ldp_pkg::LDP_DONE && !busy_o)
        else $error("commit before pair finished");
    zero_dest_a: assert property (@(posedge core_clk_i)
        disable iff (!nrst_sync_r)
        wr_en_o && wr_idx_even_o == 5'h0 |-> !wr_even_en_o)
        else $error("register zero written");
    quad_route_a: assert property (@(posedge core_clk_i)
        disable iff (!nrst_sync_r)
        quad_req_o |-> !mem_req_o && !busy_o)
        else $error("quad load ran pair path");

    // main scenarios
    pair_done_c: cover property (@(posedge core_clk_i) wr_en_o);
    trap_seen_c: cover property (@(posedge core_clk_i) trap_valid_o);
    quad_seen_c: cover property (@(posedge core_clk_i) quad_req_o);
    zero_rd_c: cover property (@(posedge core_clk_i)
        wr_en_o && !wr_even_en_o);
    le_pair_c: cover property (@(posedge core_clk_i)
        wr_en_o && little_endian_i);
endmodule : ldp_exec

// File: tb/ldp_mem_model.sv
// memory path model: delayed word answers with injectable faults
`timescale 1ns/10ps
module ldp_mem_model (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic req_i,
    input wire logic [63:0] addr_i,
    input wire logic [3:0] dly_i,
    input wire logic [5:0] flt_i,
    output logic ack_o,
    output logic [31:0] rdata_o,
    output logic [5:0] flt_o
);
    logic [3:0] cnt_r;
    logic first_r;
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ack_o <= 1'b0;
            cnt_r <= 4'h0;
            first_r <= 1'b1;
            rdata_o <= 32'h00000000;
            flt_o <= 6'h00;
        end
        else if (req_i && !ack_o && cnt_r == dly_i)
        begin
            ack_o <= 1'b1;
            cnt_r <= 4'h0;
            rdata_o <= addr_i[31:0] ^ 32'h5A00C3F0;
            // faults only ride on the first word of a pair
            flt_o <= first_r ? flt_i : 6'h00;
            first_r <= 1'b0;
        end
        else
        begin
            ack_o <= 1'b0;
            // data line is not held once the word is taken
            rdata_o <= ~rdata_o;
            flt_o <= 6'h00;
            cnt_r <= (req_i && !ack_o) ? cnt_r + 4'h1 : 4'h0;
            first_r <= first_r | !req_i;
        end
    end
endmodule : ldp_mem_model

// File: tb/ldp_exec_tb.sv
// self-checking bench for the load-pair execution block
`timescale 1ns/10ps
module ldp_exec_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic iv = 1'b0;
    ldp_pkg::ldp_issue_t iss = '0;
    logic priv_s = 1'b1;
    logic [7:0] sreg = 8'h00;
    logic le_s = 1'b0;
    logic [3:0] dly_s = 4'h0;
    logic [5:0] flt_s = 6'h00;
    logic ack, busy, req, lock, quad, wr, wre, tv;
    logic [31:0] rdata;
    logic [5:0] mf;
    logic [63:0] addr, wed, wod;
    logic [7:0] masi;
    logic [4:0] widx;
    ldp_pkg::ldp_traps_t traps;
    int n_fail = 0;
    int total_checks = 0;
    always #10 clk = ~clk;
    ldp_exec ldp_exec_inst (.core_clk_i(clk), .nrst_i(nrst),
        .issue_valid_i(iv), .issue_i(iss), .privilege_state_bit_i(priv_s),
        .space_id_reg_i(sreg), .little_endian_i(le_s), .mem_ack_i(ack),
        .mem_rdata_i(rdata), .mem_access_fault_i(mf[5]),
        .mem_access_error_i(mf[4]), .mem_translation_miss_i(mf[3]),
        .mem_protection_i(mf[2]), .mem_phys_watch_i(mf[1]),
        .mem_virt_watch_i(mf[0]), .busy_o(busy), .mem_req_o(req),
        .mem_addr_o(addr), .mem_asi_o(masi), .mem_lock_o(lock),
        .quad_req_o(quad), .wr_en_o(wr), .wr_even_en_o(wre),
        .wr_idx_even_o(widx), .wr_even_data_o(wed), .wr_odd_data_o(wod),
        .trap_valid_o(tv), .traps_o(traps));
    ldp_mem_model ldp_mem_model_inst (.clk_i(clk), .nrst_i(nrst),
        .req_i(req), .addr_i(addr), .dly_i(dly_s), .flt_i(flt_s),
        .ack_o(ack), .rdata_o(rdata), .flt_o(mf));
    task automatic tally_and_finish;
        if (n_fail == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [63:0] e,
        input logic [63:0] s);
        total_checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    function automatic logic [63:0] ld(input logic [63:0] a);
        logic [31:0] w;
        w = a[31:0] ^ 32'h5A00C3F0;
        if (le_s)
            w = {w[7:0], w[15:8], w[23:16], w[31:24]};
        return {32'h00000000, w};
    endfunction : ld
    task automatic run(input logic alt, input logic sel, input logic [4:0] rd,
        input logic [63:0] a, input logic [63:0] bi, input logic [7:0] asi);
        logic [63:0] ea;
        logic [7:0] ua;
        logic [5:0] ef;
        logic q;
        ldp_pkg::ldp_traps_t et;
        int words;
        int k;
        int ew;
        ea = sel ? a + {{51{bi[12]}}, bi[12:0]} : a + bi;
        ua = alt ? asi : 8'h80;
        ef = alt ? (flt_s & 6'h2F) : flt_s;
        et = '0;
        et.bad_opcode = rd[0];
        et.misalign = ea[2:0] != 3'h0;
        et.priv_action = alt && !priv_s && !ua[7];
        q = alt && (ua == 8'h24 || ua == 8'h2C) && et == '0;
        words = 0;
        @(negedge clk);
        iv = 1'b1;
        // the unselected operand and space id carry decoys
        iss = '{alt, sel, rd, a, sel ? ~bi : bi,
            sel ? bi[12:0] : ~bi[12:0], sel ? asi ^ 8'h0F : asi};
        sreg = sel ? asi : asi ^ 8'h0F;
        @(negedge clk);
        iv = 1'b0;
        for (k = 0; k < 60; k++)
        begin
            if (ack)
            begin
                chk("mem_addr", words ? ea + 64'h4 : ea, addr);
                chk("mem_asi", ua, masi);
                chk("mem_lock", 64'h1, lock);
                chk("busy", 64'h1, busy);
                words++;
            end
            if (wr || tv || quad)
                break;
            @(negedge clk);
        end
        if (k == 60)
        begin
            n_fail++;
            tally_and_finish();
        end
        if (et == '0 && !q)
            et[5:0] = ef;
        ew = (et == '0) ? (q ? 0 : 2) : int'(ef != 6'h00 && et[8:6] == 3'h0);
        chk("pulses", et != '0 ? 3'h4 : q ? 3'h1 : 3'h2,
            {tv, wr, quad});
        chk("words", ew, words);
        chk("busy_end", 64'h0, busy);
        chk("req_end", 64'h0, req);
        chk("lock_end", 64'h0, lock);
        if (et != '0)
            chk("traps", et, traps);
        else if (!q)
        begin
            chk("even_en", rd[4:1] != 4'h0, wre);
            chk("idx", {rd[4:1], 1'b0}, widx);
            chk("even", ld(ea), wed);
            chk("odd", ld(ea + 64'h4), wod);
        end
    endtask : run
    initial
    begin
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        run(0, 0, 5'h04, 64'hFFFFFFFF00001000, 64'h20, 8'h00);
        le_s = 1'b1;
        dly_s = 4'h3;
        run(0, 1, 5'h00, 64'h2010, 64'h1FF8, 8'h00);
        le_s = 1'b0;
        dly_s = 4'h0;
        priv_s = 1'b0;
        run(1, 0, 5'h1E, 64'h3000, 64'h8, 8'h81);
        run(1, 0, 5'h02, 64'h3000, 64'h8, 8'h10);
        priv_s = 1'b1;
        run(1, 1, 5'h06, 64'h4000, 64'h10, 8'h10);
        run(0, 0, 5'h03, 64'h100, 64'h0, 8'h00);
        run(1, 1, 5'h08, 64'h100, 64'h1FFC, 8'h88);
        run(1, 0, 5'h0A, 64'h500, 64'h8, 8'h24);
        run(1, 1, 5'h0A, 64'h500, 64'h8, 8'h2C);
        for (int i = 0; i < 6; i++)
        begin
            flt_s = 6'h01 << i;
            run(0, 0, 5'h0C, 64'h600, 64'h8, 8'h00);
            run(1, 0, 5'h0C, 64'h600, 64'h8, 8'h80);
        end
        flt_s = 6'h00;
        run(0, 0, 5'h0E, 64'h700, 64'h0, 8'h00);
        tally_and_finish();
    end
endmodule : ldp_exec_tb
